// ---- pkg/slc_cfg.svh ----
// Constants for the serial link command port: offsets, fields, reset values, timing.
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH
`define SLC_ADR_CMD       4'h0
`define SLC_ADR_DATA      4'h4
`define SLC_ADR_CHSTAT    4'h8
`define SLC_ADR_PARAM0    4'hc
`define SLC_BIT_IGNORE    31
`define SLC_BIT_WRITE     15
`define SLC_BIT_ROM       14
`define SLC_BIT_REQ       13
`define SLC_BIT_XFER      12
`define SLC_BIT_START     11
`define SLC_CMD_STOPALL   16'h0800
`define SLC_CMD_RESET     16'h0000
`define SLC_DATA_RESET    8'h00
`define SLC_PARAM_COUNT   8
`define SLC_EXEC_NS       800
`define SLC_CLK_NS        100
`define SLC_EXEC_CYC      ((`SLC_EXEC_NS + `SLC_CLK_NS - 1) / `SLC_CLK_NS)
`endif

// ---- pkg/slc_pkg.sv ----
// Types shared by the serial link command port.
package slc_pkg;
  typedef enum logic [2:0] {
    SLC_IDLE  = 3'b000,
    SLC_EXEC  = 3'b001,
    SLC_DONE  = 3'b010
  } slc_state_t;
  typedef enum logic [2:0] {
    SLC_OP_NONE    = 3'b000,
    SLC_OP_STOP    = 3'b001,
    SLC_OP_START   = 3'b010,
    SLC_OP_SETUP   = 3'b011,
    SLC_OP_XFER    = 3'b100,
    SLC_OP_LREAD   = 3'b101,
    SLC_OP_LWRITE  = 3'b110,
    SLC_OP_ROM     = 3'b111
  } slc_op_t;
endpackage : slc_pkg

// ---- sim/slc_port_sva.sv ----
// Assertion checker for the serial link command port.
`timescale 1ns/1ps
`default_nettype none
module slc_port_sva (
  // Clock, reset and bus.
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // Link control.
  input wire logic        proc_reset_o,
  input wire logic [7:0]  chan_active_o,
  input wire logic [7:0]  xfer_strobe_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A command write taken this cycle; bit 31 decides whether it counts.
  wire logic tk = cyc_i && stb_i && !ack_o;
  wire logic cw = tk && we_i && adr_i == 4'h0 && sel_i == 4'hf;
  wire logic go = cw && !dat_i[31] && !busy_o && dat_i[15:0] != 16'h0000;
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_ack_follows_take: assert property (tk |=> ack_o) else $error("no ack");
  a_cmd_launches: assert property (go |=> busy_o[*8]) else $error("no launch");
  a_cmd_completes: assert property (busy_o |-> ##[0:20] !busy_o) else $error("stuck");
  a_ignore_bit: assert property (cw && dat_i[31] && !busy_o |=> !busy_o) else $error("bit31");
  a_stop_resets: assert property (cw && dat_i == 32'h0000_0800 |-> ##[1:12]
    (chan_active_o == 8'h00 && !proc_reset_o)) else $error("stop-all");
  a_rom_reset: assert property (go && dat_i[14] |-> ##[1:12] proc_reset_o) else $error("rom");
  a_xfer_pulse: assert property (xfer_strobe_o != 8'h00 |=> xfer_strobe_o == 8'h00)
    else $error("strobe held");
  a_xfer_on_active: assert property ((xfer_strobe_o & ~chan_active_o) == 8'h00)
    else $error("strobe on idle channel");
  a_active_at_cmd: assert property (!$stable(chan_active_o) |-> busy_o || $past(busy_o))
    else $error("active moved");
  c_start: cover property (go && dat_i[15:8] == 8'h09);
  c_stop_busy: cover property (cw && busy_o && dat_i == 32'h0000_0800);
  c_ignore: cover property (cw && dat_i[31]);
endmodule : slc_port_sva
`default_nettype wire

// ---- sim/slc_port_test.sv ----
// Self-checking testbench for the serial link command port.
`timescale 1ns/1ps
`default_nettype none
module slc_port_test;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, proc_reset_o, busy_o;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [7:0]  chan_present_i, chan_active_o, xfer_strobe_o, xseen;
  int          err_total, n_compared;
  slc_port dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .chan_present_i(chan_present_i), .proc_reset_o(proc_reset_o),
    .chan_active_o(chan_active_o), .xfer_strobe_o(xfer_strobe_o), .busy_o(busy_o));
  // Free-running 10 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Collects every transfer strobe, since each one stands for a single cycle only.
  always @(posedge clk_i) begin
    if (rst_i) xseen <= 8'h00;
    else xseen <= xseen | xfer_strobe_o;
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One classic cycle; a lost ack ends the run rather than hanging it.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 50) begin
      err_total++;
      test_done();
    end
  endtask : wb
  // Polls the command register until it reads zero, within a bound.
  task automatic idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, 4'h0, 32'h0);
      n++;
    end while (rd !== 32'h0 && n < 40);
    if (n >= 40) begin
      err_total++;
      test_done();
    end
  endtask : idle
  task automatic t_start();
    chan_present_i <= 8'h5a;
    wb(1'b1, 4'h0, 32'h7ab0_09ff);
    wb(1'b0, 4'h0, 32'h0);
    chk("cmd_pending", 32'h0000_09ff, rd);
    idle();
    wb(1'b0, 4'h4, 32'h0);
    chk("fail_mask", 32'h0000_00a5, rd);
    chk("active", 32'h5a, {24'h0, chan_active_o});
    wb(1'b1, 4'h0, 32'h0000_0802);
    idle();
    chk("stop_one", 32'h58, {24'h0, chan_active_o});
    wb(1'b1, 4'h0, 32'h8000_0800);
    chk("ignored", 32'h0, {31'h0, busy_o});
    chk("ign_active", 32'h58, {24'h0, chan_active_o});
  endtask : t_start
  task automatic t_param();
    idle();
    wb(1'b1, 4'h4, 32'h0000_003c);
    wb(1'b1, 4'h0, 32'h0000_a005);
    idle();
    wb(1'b1, 4'h4, 32'h0000_00ff);
    wb(1'b1, 4'h0, 32'h0000_2005);
    idle();
    wb(1'b0, 4'h4, 32'h0);
    chk("param", 32'h0000_003c, rd);
  endtask : t_param
  task automatic t_stop();
    wb(1'b1, 4'h0, 32'h0000_1003);
    idle();
    wb(1'b0, 4'h4, 32'h0);
    chk("xfer_mask", 32'h0000_0003, rd);
    chk("no_strobe", 32'h0, {24'h0, xseen});
    wb(1'b1, 4'h0, 32'h0000_1018);
    idle();
    wb(1'b0, 4'h4, 32'h0);
    chk("xfer_ok", 32'h0, rd);
    chk("strobe", 32'h18, {24'h0, xseen});
    wb(1'b1, 4'h0, 32'h0000_4000);
    idle();
    chk("proc_reset", 32'h1, {31'h0, proc_reset_o});
    wb(1'b1, 4'h0, 32'h0000_4000);
    wb(1'b1, 4'h0, 32'h0000_0800);
    idle();
    chk("stopall", 32'h0, {23'h0, proc_reset_o, chan_active_o});
  endtask : t_stop
  // Reset for twenty cycles, then the scenarios in turn.
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 4'h0;
    sel_i = 4'hf;
    dat_i = 32'h0;
    chan_present_i = 8'h00;
    err_total = 0;
    n_compared = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 4'h4, 32'h0);
    chk("data_reset", 32'h0, rd);
    t_start();
    t_param();
    t_stop();
    test_done();
  end
endmodule : slc_port_test
bind slc_port slc_port_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
  .proc_reset_o(proc_reset_o), .chan_active_o(chan_active_o),
  .xfer_strobe_o(xfer_strobe_o), .busy_o(busy_o));
`default_nettype wire

// ---- verilog/slc_decode.sv ----
// Command word decoder: turns a 16-bit command into one operation code.
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"
module slc_decode (
  // Command in.
  input  wire logic [15:0]     cmd_i,
  // Decoded operation.
  output slc_pkg::slc_op_t     op_o
);
  // Reset/ROM wins, then the start/stop group, transfer, then parameter access.
  always_comb begin
    op_o = slc_pkg::SLC_OP_NONE;
    if (cmd_i[`SLC_BIT_ROM]) begin
      op_o = slc_pkg::SLC_OP_ROM;
    end else if (cmd_i[`SLC_BIT_START]) begin
      case (cmd_i[10:8])
        3'b000:  op_o = slc_pkg::SLC_OP_STOP;
        3'b001:  op_o = slc_pkg::SLC_OP_START;
        3'b111:  op_o = slc_pkg::SLC_OP_SETUP;
        default: op_o = slc_pkg::SLC_OP_NONE;
      endcase
    end else if (cmd_i[`SLC_BIT_XFER]) begin
      op_o = slc_pkg::SLC_OP_XFER;
    end else if (cmd_i[`SLC_BIT_REQ]) begin
      op_o = cmd_i[`SLC_BIT_WRITE] ? slc_pkg::SLC_OP_LWRITE : slc_pkg::SLC_OP_LREAD;
    end
  end
endmodule : slc_decode
`default_nettype wire

// ---- verilog/slc_port.sv ----
// Serial link command port: Wishbone command and data registers with a command sequencer.
// Summary of operation
// - Command register is 16 bits, low end of a 32-bit word; upper bits read zero.
// - Bit 15 marks a parameter write instead of a read.
// - Bit 14 holds the link processor in reset or opens program memory.
// - Bit 13 flags parameter access for every local read or write.
// - Bit 12 runs a data transfer on the masked channels.
// - With bit 11, type 000 stops, 001 starts normal, 111 starts setup.
// - Each set mask bit makes that channel join start, stop or transfer.
// - Writing the command register launches the command by itself.
// - Finishing any command clears the command register to zero.
// - While executing, the command register reads back the written value.
// - Stop-all is accepted any time, even pending, and resets the interface.
// - Writes with bit 31 set are discarded, at any time; here only command writes with sel_i[3] set are, not data writes.
// - Eight-bit data register, low byte of a 32-bit word, reaches parameters.
// - After the register reads zero, the data register holds the parameter byte.
// - Stop-all value 0x0800 resets all channel variables; here it clears active, processor reset and data, not the parameter bytes.
// - After a start, data holds a mask of channels that failed to start.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"
module slc_port (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Link side: channel presence from the serial lines, sampled here.
  input  wire logic [7:0]  chan_present_i,
  // Link control outputs.
  output logic             proc_reset_o,
  output logic [7:0]       chan_active_o,
  output logic [7:0]       xfer_strobe_o,
  output logic             busy_o
);
  // Whole module state in one record.
  typedef struct packed {
    logic [15:0]          cmd;
    logic [7:0]           data;
    logic [7:0]           active;
    logic [7:0]           xfer;
    logic                 rom;
    logic                 ack;
    logic [31:0]          rdat;
    slc_pkg::slc_state_t  state;
    slc_pkg::slc_op_t     op;
    logic [3:0]           cnt;
    logic [7:0]           pres_meta;
    logic [7:0]           pres;
    // Packed so that the parameter bytes can live inside the packed state record.
    logic [`SLC_PARAM_COUNT-1:0][7:0] params;
  } slc_state_rec_t;

  slc_state_rec_t     st_reg;
  slc_state_rec_t     st_next;
  slc_pkg::slc_op_t   wr_op;
  slc_pkg::slc_op_t   cur_op;
  logic               req;
  logic               wr_cmd;
  logic               wr_data;
  logic [2:0]         pidx;

  localparam logic [3:0] EXEC_CYC = 4'(`SLC_EXEC_CYC);

  // Decode of the incoming write value and of the stored command.
  slc_decode u_dec_wr (
    .cmd_i (dat_i[15:0]),
    .op_o  (wr_op)
  );
  slc_decode u_dec_cur (
    .cmd_i (st_reg.cmd),
    .op_o  (cur_op)
  );

  // A request is answered one cycle after it is taken; ack drops the cycle after.
  assign req     = cyc_i && stb_i && !st_reg.ack;
  assign wr_cmd  = req && we_i && (adr_i == `SLC_ADR_CMD) && sel_i[0] && sel_i[1]
                   && !(sel_i[3] && dat_i[`SLC_BIT_IGNORE]);
  assign wr_data = req && we_i && (adr_i == `SLC_ADR_DATA) && sel_i[0];
  assign pidx    = st_reg.cmd[2:0];

  always_comb begin
    st_next = st_reg;
    st_next.ack = req;
    // Two-flop sampling of the channel presence lines; only pres is read.
    st_next.pres_meta = chan_present_i;
    st_next.pres      = st_reg.pres_meta;
    st_next.xfer      = 8'h00;
    // Read path: upper bits read as zero.
    st_next.rdat = 32'h0000_0000;
    if (req && !we_i) begin
      case (adr_i)
        `SLC_ADR_CMD:    st_next.rdat = {16'h0000, st_reg.cmd};
        `SLC_ADR_DATA:   st_next.rdat = {24'h000000, st_reg.data};
        `SLC_ADR_CHSTAT: st_next.rdat = {24'h000000, st_reg.active};
        default:         st_next.rdat = 32'h0000_0000;
      endcase
    end
    if (wr_data) begin
      st_next.data = dat_i[7:0];
    end
    // Sequencer: execution starts on the write itself.
    case (st_reg.state)
      slc_pkg::SLC_IDLE: begin
        st_next.cnt = 4'h0;
      end
      slc_pkg::SLC_EXEC: begin
        st_next.cnt = st_reg.cnt + 4'h1;
        if (st_reg.cnt == EXEC_CYC - 4'h1) begin
          st_next.state = slc_pkg::SLC_DONE;
        end
      end
      slc_pkg::SLC_DONE: begin
        // Apply the command effect, then report completion.
        case (cur_op)
          slc_pkg::SLC_OP_STOP: begin
            st_next.active = st_reg.active & ~st_reg.cmd[7:0];
          end
          slc_pkg::SLC_OP_START, slc_pkg::SLC_OP_SETUP: begin
            st_next.active = st_reg.active | (st_reg.cmd[7:0] & st_reg.pres);
            st_next.data   = st_reg.cmd[7:0] & ~st_reg.pres;
          end
          slc_pkg::SLC_OP_XFER: begin
            st_next.xfer = st_reg.cmd[7:0] & st_reg.active;
            st_next.data = st_reg.cmd[7:0] & ~st_reg.active;
          end
          slc_pkg::SLC_OP_LREAD: begin
            st_next.data = st_reg.params[pidx];
          end
          slc_pkg::SLC_OP_LWRITE: begin
            st_next.params[pidx] = st_reg.data;
          end
          slc_pkg::SLC_OP_ROM: begin
            st_next.rom = 1'b1;
          end
          default: begin
          end
        endcase
        st_next.cmd   = `SLC_CMD_RESET;
        st_next.state = slc_pkg::SLC_IDLE;
      end
      default: begin
        st_next.state = slc_pkg::SLC_IDLE;
      end
    endcase
    // A command write launches execution; stop-all is taken even while busy.
    if (wr_cmd) begin
      if (dat_i[15:0] == `SLC_CMD_STOPALL) begin
        st_next.cmd    = dat_i[15:0];
        st_next.active = 8'h00;
        st_next.rom    = 1'b0;
        st_next.data   = `SLC_DATA_RESET;
        st_next.cnt    = 4'h0;
        st_next.state  = slc_pkg::SLC_EXEC;
      end else if (st_reg.state == slc_pkg::SLC_IDLE) begin
        // A write while busy is undefined for the host; it is dropped here.
        st_next.cmd   = dat_i[15:0];
        st_next.cnt   = 4'h0;
        st_next.state = slc_pkg::SLC_EXEC;
        if (wr_op == slc_pkg::SLC_OP_NONE) begin
          st_next.cmd = dat_i[15:0];
        end
        if (wr_op != slc_pkg::SLC_OP_ROM) begin
          st_next.rom = 1'b0;
        end
      end
    end
  end

  // Register the whole state; reset loads constants only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.cmd       <= `SLC_CMD_RESET;
      st_reg.data      <= `SLC_DATA_RESET;
      st_reg.active    <= 8'h00;
      st_reg.xfer      <= 8'h00;
      st_reg.rom       <= 1'b0;
      st_reg.ack       <= 1'b0;
      st_reg.rdat      <= 32'h0000_0000;
      st_reg.state     <= slc_pkg::SLC_IDLE;
      st_reg.op        <= slc_pkg::SLC_OP_NONE;
      st_reg.cnt       <= 4'h0;
      st_reg.pres_meta <= 8'h00;
      st_reg.pres      <= 8'h00;
      for (int i = 0; i < `SLC_PARAM_COUNT; i++) begin
        st_reg.params[i] <= 8'h00;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state record.
  assign dat_o         = st_reg.rdat;
  assign ack_o         = st_reg.ack;
  assign proc_reset_o  = st_reg.rom;
  assign chan_active_o = st_reg.active;
  assign xfer_strobe_o = st_reg.xfer;
  assign busy_o        = (st_reg.state != slc_pkg::SLC_IDLE);
endmodule : slc_port
`default_nettype wire
